/* File: src/mpt_core.sv */
// six-output motor pwm core: timebase, buffered settings, pins
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// R1: six outputs run as six channels or three complementary pairs.
// R2: one shared timer; six compare values; pairs of high and low.
// R3: complementary pairs get dead time so both never overlap active.
// R4: high-side off level equals its option bit; active is inverse.
// R5: low-side option bit sets low outputs the same way.
// R6: off levels and pair enables are options software cannot change.
// R7: swap bit clear: high leads period; set: low leads.
// R8: swap change applies at reload, then after dead time if paired.
// R9: pins high impedance in reset, then driven to off level.
// R10: each pair has its own enable option; disabled stays undriven.
// R11: duty and prescale settings are double buffered, applied together.
// R12: reload every period, or every 2, 4 or 8 periods.
// R13: software sets ready; transfer at first reload after it.
// R14: two-bit divider selects count clock of 1, 2, 4, 8.
// R15: edge mode counts up to reload, wraps to zero.
// R16: center mode counts up to reload then down to zero.
// R17: fault forces enabled outputs off without a clock.
// R18: signed duty vs count: <=0 never active, >reload always.
// R19: dead time counts system clocks 1..255, cut from active time.
// R20: converter trigger at period end, plus mid-period when centered.
// R21: period ends at wrap in edge mode, at zero going down.
module mpt_core
  import mpt_pkg::*;
#(
  parameter int CW = CNT_W,
  parameter int DW = DEAD_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  input wire mpt_opt_t optIn,
  input wire logic faultN,
  output logic [PAIRS-1:0] highOut,
  output logic [PAIRS-1:0] highOe,
  output logic [PAIRS-1:0] lowOut,
  output logic [PAIRS-1:0] lowOe,
  output logic convTrig
);

  // last count of a divide-by-2^sel counter; serves prescale and interval
  function automatic logic [2:0] divLimit(input logic [1:0] sel);
    divLimit = 3'((4'h1 << sel) - 4'h1);
  endfunction : divLimit

  // ---- state declarations ----
  mpt_opt_t opt_q, opt_d;
  logic optLoaded_q, optLoaded_d;
  logic drive_q, drive_d;

  mpt_cfg_t shadow_q, shadow_d;
  mpt_cfg_t act_q, act_d;
  logic run_q, run_d;
  logic ready_q, ready_d;
  logic trigEn_q, trigEn_d;
  logic center_q, center_d;
  logic indep_q, indep_d;
  logic [1:0] relIvl_q, relIvl_d;
  logic [DW-1:0] dead_q, dead_d;
  logic [DATA_W-1:0] rdData_q, rdData_d;

  logic [2:0] prescCnt_q, prescCnt_d;
  logic [CW-1:0] count_q, count_d;
  mpt_dir_t dir_q, dir_d;
  logic [2:0] relCnt_q, relCnt_d;
  logic trig_q, trig_d;

  logic tick;
  logic periodEnd;
  logic midPeriod;
  logic reloadEv;
  logic xfer;
  logic [CHANS-1:0] cmp;
  logic [PAIRS-1:0] hiAct;
  logic [PAIRS-1:0] loAct;
  logic [2:0] dutyIdx;

  // ---- option capture: straps taken after reset release, never later ----
  always_comb begin
    opt_d = opt_q;
    optLoaded_d = 1'b1;
    drive_d = optLoaded_q; // pins enabled one cycle after levels settle
    if (!optLoaded_q) begin
      opt_d = optIn; // [R6]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      opt_q <= '0;
      optLoaded_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      opt_q <= opt_d;
      optLoaded_q <= optLoaded_d;
      drive_q <= drive_d;
    end
  end

  // ---- timebase: prescaler, up or up/down counter, reload interval ----
  always_comb begin
    prescCnt_d = prescCnt_q;
    count_d = count_q;
    dir_d = dir_q;
    relCnt_d = relCnt_q;
    tick = 1'b0;
    periodEnd = 1'b0;
    midPeriod = 1'b0;
    reloadEv = 1'b0;
    if (!run_q) begin
      prescCnt_d = '0;
      count_d = '0;
      dir_d = CNT_UP;
      relCnt_d = '0;
    end else if (prescCnt_q >= divLimit(act_q.countClockDivideSel)) begin
      tick = 1'b1; // [R14]
      prescCnt_d = '0;
    end else begin
      prescCnt_d = prescCnt_q + 3'h1;
    end
    if (tick) begin
      case (dir_q)
        CNT_UP: begin
          if (count_q >= act_q.reload) begin
            if (center_q && act_q.reload != '0) begin
              dir_d = CNT_DOWN; // turn at the top [R16]
              count_d = count_q - CW'(1);
              midPeriod = 1'b1;
            end else begin
              count_d = '0; // wrap ends the period [R15] [R21]
              periodEnd = 1'b1;
            end
          end else begin
            count_d = count_q + CW'(1);
          end
        end
        CNT_DOWN: begin
          if (count_q <= CW'(1)) begin
            count_d = '0; // reaching zero going down [R16] [R21]
            dir_d = CNT_UP;
            periodEnd = 1'b1;
          end else begin
            count_d = count_q - CW'(1);
          end
        end
        default: dir_d = CNT_UP;
      endcase
    end
    if (periodEnd) begin
      if (relCnt_q >= divLimit(relIvl_q)) begin
        reloadEv = 1'b1; // every 1, 2, 4 or 8 periods [R12]
        relCnt_d = '0;
      end else begin
        relCnt_d = relCnt_q + 3'h1;
      end
    end
  end

  assign xfer = reloadEv && ready_q; // [R13]

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prescCnt_q <= '0;
      count_q <= '0;
      dir_q <= CNT_UP;
      relCnt_q <= '0;
    end else begin
      prescCnt_q <= prescCnt_d;
      count_q <= count_d;
      dir_q <= dir_d;
      relCnt_q <= relCnt_d;
    end
  end

  // ---- register port and buffered settings ----
  assign dutyIdx = 3'(regAddr - ADR_DUTY0);

  always_comb begin
    shadow_d = shadow_q;
    act_d = act_q;
    run_d = run_q;
    ready_d = ready_q;
    trigEn_d = trigEn_q;
    center_d = center_q;
    indep_d = indep_q;
    relIvl_d = relIvl_q;
    dead_d = dead_q;
    rdData_d = '0;
    // whole buffered set moves in one cycle [R11]
    if (xfer) begin
      act_d = shadow_q; // [R8] [R14]
      ready_d = 1'b0;
    end
    if (regWr) begin
      case (regAddr)
        ADR_CTRL0: begin
          run_d = regWrData[C0_RUN];
          trigEn_d = regWrData[C0_TRIG_EN];
          // mode only changes while stopped, counter shape stays sane
          if (!run_q) begin
            center_d = regWrData[C0_CENTER];
          end
          if (regWrData[C0_READY]) begin
            ready_d = 1'b1; // set wins over the transfer clear [R13]
          end
        end
        ADR_CTRL1: begin
          if (!run_q) begin
            indep_d = regWrData[C1_INDEP];
          end
          shadow_d.pairPolaritySwap = regWrData[C1_POL_LSB +: 3];
          relIvl_d = regWrData[C1_RELIVL_LSB +: 2];
          shadow_d.countClockDivideSel = regWrData[C1_DIV_LSB +: 2];
        end
        ADR_RELOAD: shadow_d.reload = regWrData[CW-1:0];
        ADR_DEAD: dead_d = regWrData[DW-1:0];
        default: begin
          if (regAddr >= ADR_DUTY0 && regAddr <= ADR_DUTY5) begin
            shadow_d.dutyValue[dutyIdx] = regWrData;
          end
        end
      endcase
    end
    // read data stand in the cycle after the strobe; unmapped reads zero
    if (regRd) begin
      case (regAddr)
        ADR_CTRL0: begin
          rdData_d[C0_RUN] = run_q;
          rdData_d[C0_READY] = ready_q;
          rdData_d[C0_TRIG_EN] = trigEn_q;
          rdData_d[C0_CENTER] = center_q;
        end
        ADR_CTRL1: begin
          rdData_d[C1_INDEP] = indep_q;
          rdData_d[C1_POL_LSB +: 3] = shadow_q.pairPolaritySwap;
          rdData_d[C1_RELIVL_LSB +: 2] = relIvl_q;
          rdData_d[C1_DIV_LSB +: 2] = shadow_q.countClockDivideSel;
        end
        ADR_RELOAD: rdData_d[CW-1:0] = shadow_q.reload;
        ADR_DEAD: rdData_d[DW-1:0] = dead_q;
        ADR_COUNT: begin
          rdData_d[CW-1:0] = count_q;
          rdData_d[ST_DIR_BIT] = (dir_q == CNT_DOWN);
        end
        default: begin
          if (regAddr >= ADR_DUTY0 && regAddr <= ADR_DUTY5) begin
            rdData_d = shadow_q.dutyValue[dutyIdx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shadow_q <= '{dutyValue: '{default: DUTY_RST}, reload: RELOAD_RST,
                    countClockDivideSel: 2'h0, pairPolaritySwap: 3'h0};
      act_q <= '{dutyValue: '{default: DUTY_RST}, reload: RELOAD_RST,
                 countClockDivideSel: 2'h0, pairPolaritySwap: 3'h0};
      run_q <= 1'b0;
      ready_q <= 1'b0;
      trigEn_q <= 1'b0;
      center_q <= 1'b0;
      indep_q <= 1'b0;
      relIvl_q <= 2'h0;
      dead_q <= DEAD_RST;
      rdData_q <= '0;
    end else begin
      shadow_q <= shadow_d;
      act_q <= act_d;
      run_q <= run_d;
      ready_q <= ready_d;
      trigEn_q <= trigEn_d;
      center_q <= center_d;
      indep_q <= indep_d;
      relIvl_q <= relIvl_d;
      dead_q <= dead_d;
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

  // ---- compare: signed duty against the unsigned count ----
  always_comb begin
    for (int i = 0; i < CHANS; i++) begin
      cmp[i] = run_q &&
        ($signed({4'h0, count_q}) < $signed(act_q.dutyValue[i])); // [R2] [R18]
    end
  end

  // even channels drive the high side, odd ones the low side
  for (genvar p = 0; p < PAIRS; p++) begin : g_pair
    mpt_pair #(.DW(DW)) u_pair (
      .mclk(mclk),
      .rst(rst),
      .run(run_q),
      .cmpHi(cmp[2*p]),
      .cmpLo(cmp[2*p+1]),
      .polSwap(act_q.pairPolaritySwap[p]),
      .indep(indep_q),
      .deadCycles(dead_q),
      .hiAct(hiAct[p]),
      .loAct(loAct[p])
    );
  end

  // ---- converter trigger ----
  always_comb begin
    trig_d = trigEn_q && (periodEnd || midPeriod); // [R20]
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_d;
    end
  end

  assign convTrig = trig_q;

  // ---- pins: fault path is purely combinational, works without a clock ----
  assign highOut = {PAIRS{opt_q.hiOffLevel}} ^ (hiAct & {PAIRS{faultN}}); // [R4] [R17]
  assign lowOut = {PAIRS{opt_q.loOffLevel}} ^ (loAct & {PAIRS{faultN}}); // [R5] [R17]
  assign highOe = {PAIRS{drive_q}} & opt_q.pairEnable; // [R9] [R10]
  assign lowOe = {PAIRS{drive_q}} & opt_q.pairEnable; // [R9] [R10]

  // ---- checks ----
  a_fault_forces_off: assert property (@(posedge mclk) // [R17]
    disable iff (rst) !faultN |-> (highOut == {PAIRS{opt_q.hiOffLevel}}
                 && lowOut == {PAIRS{opt_q.loOffLevel}}))
    else $error("fault did not force off levels");

  a_disabled_pair_hiz: assert property (@(posedge mclk) // [R10]
    disable iff (rst) (highOe & ~opt_q.pairEnable) == '0
    && (lowOe & ~opt_q.pairEnable) == '0 && (optLoaded_q || highOe == '0))
    else $error("disabled pair driven");

  a_ready_clears: assert property (@(posedge mclk) disable iff (rst) // [R13]
    (xfer && !(regWr && regAddr == ADR_CTRL0 && regWrData[C0_READY]))
    |=> !ready_q && act_q == $past(shadow_q))
    else $error("transfer failed or ready stuck");

  a_active_held: assert property (@(posedge mclk) disable iff (rst) // [R11]
    !xfer |=> $stable(act_q))
    else $error("active set changed outside reload");

  a_edge_wrap: assert property (@(posedge mclk) disable iff (rst) // [R15]
    (tick && !center_q && count_q >= act_q.reload) |=> count_q == '0)
    else $error("edge counter did not wrap");

  a_center_turn: assert property (@(posedge mclk) disable iff (rst) // [R16]
    (tick && center_q && dir_q == CNT_UP && count_q == act_q.reload
     && act_q.reload > CW'(1))
    |=> dir_q == CNT_DOWN && count_q == $past(act_q.reload) - CW'(1))
    else $error("center counter did not turn");

  a_presc_div8: assert property (@(posedge mclk) disable iff (rst) // [R14]
    (tick && act_q.countClockDivideSel == 2'h3 && run_q && !xfer)
    |=> (!tick)[*7])
    else $error("divide by eight ticked early");

  a_trig_pulse: assert property (@(posedge mclk) disable iff (rst) // [R20]
    (trigEn_q && periodEnd) |=> convTrig)
    else $error("converter trigger missing");

  a_duty_low: assert property (@(posedge mclk) disable iff (rst) // [R18]
    ($signed(act_q.dutyValue[0]) <= 0) |-> !cmp[0])
    else $error("non-positive duty became active");

endmodule : mpt_core

/* File: src/mpt_pkg.sv */
// constants, field layout and carrier types of the motor pwm timebase core
package mpt_pkg;

  // bus and datapath widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 12;
  localparam int DEAD_W = 8;
  localparam int PAIRS = 3;
  localparam int CHANS = 6;

  // register offsets (word index on the plain register port)
  localparam logic [3:0] ADR_CTRL0 = 4'h0;
  localparam logic [3:0] ADR_CTRL1 = 4'h1;
  localparam logic [3:0] ADR_RELOAD = 4'h2;
  localparam logic [3:0] ADR_DEAD = 4'h3;
  localparam logic [3:0] ADR_DUTY0 = 4'h4;
  localparam logic [3:0] ADR_DUTY5 = 4'h9;
  localparam logic [3:0] ADR_COUNT = 4'ha;

  // modulator_control_zero fields
  localparam int C0_RUN = 0;
  localparam int C0_READY = 1;
  localparam int C0_TRIG_EN = 2;
  localparam int C0_CENTER = 3;

  // modulator_control_one fields
  localparam int C1_INDEP = 0;
  localparam int C1_POL_LSB = 1;
  localparam int C1_RELIVL_LSB = 4;
  localparam int C1_DIV_LSB = 6;

  // count status fields
  localparam int ST_DIR_BIT = 15;

  // reset values
  localparam logic [11:0] RELOAD_RST = 12'hfff;
  localparam logic [7:0] DEAD_RST = 8'h01;
  localparam logic [15:0] DUTY_RST = 16'h0000;

  // option bits sampled once after reset
  typedef struct packed {
    logic hiOffLevel;
    logic loOffLevel;
    logic [2:0] pairEnable;
  } mpt_opt_t;

  // double-buffered timing set
  typedef struct packed {
    logic [5:0][15:0] dutyValue;
    logic [11:0] reload;
    logic [1:0] countClockDivideSel;
    logic [2:0] pairPolaritySwap;
  } mpt_cfg_t;

  typedef enum logic [0:0] {
    CNT_UP = 1'b0,
    CNT_DOWN = 1'b1
  } mpt_dir_t;

  typedef enum logic [0:0] {
    PS_STEADY = 1'b0,
    PS_DEAD = 1'b1
  } mpt_pst_t;

endpackage : mpt_pkg

/* File: src/mpt_pair.sv */
// one output pair: independent drive or complementary with dead time
`timescale 1ns/1ps
module mpt_pair
  import mpt_pkg::*;
#(
  parameter int DW = DEAD_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic cmpHi,
  input wire logic cmpLo,
  input wire logic polSwap,
  input wire logic indep,
  input wire logic [DW-1:0] deadCycles,
  output logic hiAct,
  output logic loAct
);

  mpt_pst_t st_q, st_d;
  logic side_q, side_d;
  logic [DW-1:0] cnt_q, cnt_d;
  logic hi_q, hi_d;
  logic lo_q, lo_d;
  logic wantHi;

  // swap bit picks which side leads the period
  assign wantHi = cmpHi ^ polSwap; // [R7]

  // next state of the pair
  always_comb begin
    st_d = st_q;
    side_d = side_q;
    cnt_d = cnt_q;
    hi_d = 1'b0;
    lo_d = 1'b0;
    if (!run) begin
      st_d = PS_STEADY;
      side_d = wantHi;
    end else if (indep) begin
      st_d = PS_STEADY; // [R1]
      side_d = wantHi;
      hi_d = wantHi;
      lo_d = cmpLo ^ polSwap;
    end else begin
      case (st_q)
        PS_STEADY: begin
          if (wantHi != side_q) begin
            // both off while the dead time runs; also delays a swap [R3] [R8]
            st_d = PS_DEAD;
            cnt_d = (deadCycles == '0) ? DW'(1) : deadCycles; // [R19]
          end else begin
            hi_d = side_q;
            lo_d = ~side_q;
          end
        end
        PS_DEAD: begin
          if (cnt_q <= DW'(1)) begin
            // new side starts at the last dead clock, so gap equals count
            st_d = PS_STEADY;
            side_d = wantHi;
            hi_d = wantHi; // [R19]
            lo_d = ~wantHi;
          end else begin
            cnt_d = cnt_q - DW'(1); // undivided system clocks [R19]
          end
        end
        default: st_d = PS_STEADY;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= PS_STEADY;
      side_q <= 1'b0;
      cnt_q <= '0;
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      st_q <= st_d;
      side_q <= side_d;
      cnt_q <= cnt_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end

  assign hiAct = hi_q;
  assign loAct = lo_q;

  a_pair_no_overlap: assert property (@(posedge mclk) // [R3]
    disable iff (rst) !indep |-> !(hiAct && loAct))
    else $error("pair sides active together");

  a_dead_gap_bound: assert property (@(posedge mclk) // [R19]
    disable iff (rst) (run && !indep && $stable(indep) && st_q == PS_STEADY
     && wantHi != side_q)
    |=> (!hiAct && !loAct) ##[0:255] (st_q == PS_STEADY))
    else $error("dead time missing or too long");

endmodule : mpt_pair

/* File: test/mpt_gate_drv.sv */
// gate-drive model: resolves pin levels and flags shoot-through
`timescale 1ns/1ps
module mpt_gate_drv
  import mpt_pkg::*;
#(
  parameter logic HI_OFF = 1'b1,
  parameter logic LO_OFF = 1'b0
) (
  input wire logic mclk,
  input wire logic [PAIRS-1:0] highOut,
  input wire logic [PAIRS-1:0] highOe,
  input wire logic [PAIRS-1:0] lowOut,
  input wire logic [PAIRS-1:0] lowOe,
  output logic [PAIRS-1:0] hiPin,
  output logic [PAIRS-1:0] loPin,
  output int overlapCnt
);
  logic floatQ = 1'b0;

  // an undriven pin wanders, so it never holds the last level
  always @(posedge mclk) begin
    floatQ <= ~floatQ;
  end

  // pin level from driver when enabled, else the wandering level
  assign hiPin = (highOe & highOut) | (~highOe & {PAIRS{floatQ}});
  assign loPin = (lowOe & lowOut) | (~lowOe & {PAIRS{floatQ}});

  // both switches of one leg on is a short across the supply
  initial overlapCnt = 0;
  always @(negedge mclk) begin
    for (int i = 0; i < PAIRS; i++) begin
      if (highOe[i] && hiPin[i] !== HI_OFF && loPin[i] !== LO_OFF) begin
        overlapCnt++;
      end
    end
  end
endmodule : mpt_gate_drv

/* File: test/tb.sv */
// self-checking bench of the motor pwm core with a gate-drive model
`timescale 1ns/1ps
module tb;
  import mpt_pkg::*;
  typedef struct packed {
    logic [3:0] a;
    logic wr;
    logic [15:0] d;
    logic [15:0] exp;
  } mpt_row_t;

  localparam logic [15:0] RUN = 16'h0001 << C0_RUN;
  localparam logic [15:0] READY = 16'h0001 << C0_READY;
  localparam logic [15:0] TRIG = 16'h0001 << C0_TRIG_EN;
  localparam logic [15:0] CENTER = 16'h0001 << C0_CENTER;
  localparam logic [15:0] INDEP = 16'h0001 << C1_INDEP;
  localparam logic [15:0] POL0 = 16'h0001 << C1_POL_LSB;
  localparam logic [15:0] DIV2 = 16'h0001 << C1_DIV_LSB;
  localparam logic [15:0] DIV8 = 16'h0003 << C1_DIV_LSB;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = 4'h0;
  logic [DATA_W-1:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DATA_W-1:0] regRdData;
  mpt_opt_t optIn = '{hiOffLevel: 1'b1, loOffLevel: 1'b0, pairEnable: 3'h3};
  logic faultN = 1'b1;
  logic [PAIRS-1:0] highOut, highOe, lowOut, lowOe, hiPin, loPin;
  logic convTrig;
  logic [15:0] rdv;
  int overlapCnt, ov0, hiOn, loOn, gapN, trigN;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  // register traffic: reset values, read-back, unmapped places
  mpt_row_t rows [9] = '{
    '{ADR_RELOAD, 1'b0, 16'h0000, 16'h0fff},
    '{ADR_DEAD, 1'b0, 16'h0000, 16'h0001},
    '{ADR_DUTY0, 1'b0, 16'h0000, 16'h0000},
    '{ADR_RELOAD, 1'b1, 16'h0009, 16'h0009},
    '{ADR_DEAD, 1'b1, 16'h0002, 16'h0002},
    '{ADR_DUTY0, 1'b1, 16'h0004, 16'h0004},
    '{4'h5, 1'b1, 16'h0004, 16'h0004},
    '{4'hb, 1'b1, 16'hbeef, 16'h0000},
    '{4'hf, 1'b0, 16'h0000, 16'h0000}};

  mpt_core dut_u (.mclk(mclk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .optIn(optIn), .faultN(faultN),
    .highOut(highOut), .highOe(highOe), .lowOut(lowOut),
    .lowOe(lowOe), .convTrig(convTrig));

  mpt_gate_drv #(.HI_OFF(1'b1), .LO_OFF(1'b0)) drv_u (.mclk(mclk),
    .highOut(highOut), .highOe(highOe), .lowOut(lowOut), .lowOe(lowOe),
    .hiPin(hiPin), .loPin(loPin), .overlapCnt(overlapCnt));

  always #25 mclk = ~mclk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rdv = regRdData;
  endtask : rd

  // set ready and wait until the device takes the buffered set
  task automatic apply(input logic [15:0] c0);
    int k;
    wr(ADR_CTRL0, c0 | READY);
    k = 0;
    rdv = READY;
    while ((rdv & READY) != 16'h0000 && k < 3000) begin
      rd(ADR_CTRL0);
      k++;
    end
    chk(rdv & READY, 16'h0000);
  endtask : apply

  // pair 0 activity over n cycles, taken mid-cycle
  task automatic meas(input int n);
    hiOn = 0;
    loOn = 0;
    gapN = 0;
    trigN = 0;
    repeat (n) begin
      @(negedge mclk);
      hiOn += int'(hiPin[0] !== 1'b1);
      loOn += int'(loPin[0] !== 1'b0);
      gapN += int'(hiPin[0] === 1'b1 && loPin[0] === 1'b0);
      trigN += int'(convTrig === 1'b1);
    end
  endtask : meas

  task automatic final_report;
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // hang guard well above the longest expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    #1 chk(16'({highOe, lowOe}), 16'h0000);
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    // straps flipped after capture must change nothing
    optIn <= '{hiOffLevel: 1'b0, loOffLevel: 1'b1, pairEnable: 3'h4};
    repeat (3) @(posedge mclk);
    #1 chk(16'({highOe, lowOe}), 16'h001b);
    chk(16'(highOut[1:0]), 16'h0003);
    chk(16'(lowOut[1:0]), 16'h0000);
    chk(16'({highOe[2], highOut[0]}), 16'h0001);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(rdv, rows[i].exp);
    end
    // independent edge mode, period of ten counts
    wr(ADR_CTRL1, INDEP);
    apply(RUN | TRIG);
    meas(100);
    chk(16'(hiOn), 16'h0028);
    chk(16'(loOn), 16'h0028);
    chk(16'(trigN), 16'h000a);
    // duty below zero and above reload
    wr(ADR_DUTY0, 16'hfffb);
    wr(4'h5, 16'h000a);
    apply(RUN | TRIG);
    meas(100);
    chk(16'(hiOn), 16'h0000);
    chk(16'(loOn), 16'h0064);
    // new divider and duty stay parked until ready
    wr(ADR_CTRL1, INDEP | DIV2);
    wr(ADR_DUTY0, 16'h0004);
    meas(100);
    chk(16'(hiOn), 16'h0000);
    apply(RUN | TRIG);
    meas(200);
    chk(16'(hiOn), 16'h0050);
    chk(16'(trigN), 16'h000a);
    wr(ADR_CTRL1, INDEP | POL0);
    apply(RUN | TRIG);
    meas(100);
    chk(16'(hiOn), 16'h003c);
    chk(16'(loOn), 16'h0000);
    // complementary pair, two-clock dead time
    wr(ADR_CTRL0, 16'h0000);
    wr(ADR_CTRL1, 16'h0000);
    apply(RUN);
    // first period after the reload has no edge at its start, skip it
    repeat (10) @(posedge mclk);
    ov0 = overlapCnt;
    meas(100);
    chk(16'(hiOn), 16'h0014);
    chk(16'(loOn), 16'h0028);
    chk(16'(gapN), 16'h0028);
    wr(ADR_CTRL1, POL0);
    meas(100);
    chk(16'(hiOn), 16'h0014);
    apply(RUN);
    repeat (10) @(posedge mclk);
    meas(100);
    chk(16'(hiOn), 16'h0028);
    chk(16'(loOn), 16'h0014);
    chk(16'(overlapCnt - ov0), 16'h0000);
    // center mode: eighteen clocks, trigger at both ends
    wr(ADR_CTRL0, CENTER);
    apply(RUN | TRIG | CENTER);
    meas(180);
    chk(16'(trigN), 16'h0014);
    // divide by eight: period of 144 clocks, two triggers each
    wr(ADR_CTRL1, POL0 | DIV8);
    apply(RUN | TRIG | CENTER);
    meas(288);
    chk(16'(trigN), 16'h0004);
    @(posedge mclk);
    faultN <= 1'b0;
    meas(50);
    chk(16'(hiOn + loOn), 16'h0000);
    @(posedge mclk);
    faultN <= 1'b1;
    final_report();
  end
endmodule : tb
